// [logic/cdt_map.svh]
`ifndef CDT_MAP_SVH
`define CDT_MAP_SVH

// Register byte offsets from the module base
`define CDT_OFF_TEST_WORD_LOW    16'h103A
`define CDT_OFF_CRATE_NUMBER     16'h103C
`define CDT_OFF_TEST_EVENT_WR    16'h103E
`define CDT_OFF_EVENT_CNT_CLEAR  16'h1040
`define CDT_OFF_PEDESTAL         16'h1060
`define CDT_OFF_READ_TEST_ADDR   16'h1064
`define CDT_OFF_SOFTWARE_CONV    16'h1068
`define CDT_OFF_SLIDE_CONSTANT   16'h106A
`define CDT_OFF_ADC_BLOCK_A      16'h1070
`define CDT_OFF_ADC_BLOCK_B      16'h1072
`define CDT_OFF_THRESHOLD_BASE   16'h1080
`define CDT_OFF_THRESHOLD_LAST   16'h10BE
`define CDT_OFF_MAKER_ID_HIGH    16'h8026
`define CDT_OFF_MAKER_ID_MID     16'h802A
`define CDT_OFF_MAKER_ID_LOW     16'h802E
`define CDT_OFF_PURCHASED_VER    16'h8032
`define CDT_OFF_BOARD_CODE_HIGH  16'h8036
`define CDT_OFF_BOARD_CODE_MID   16'h803A
`define CDT_OFF_BOARD_CODE_LOW   16'h803E
`define CDT_OFF_HW_REVISION      16'h804E
`define CDT_OFF_SERIAL_HIGH      16'h8F02
`define CDT_OFF_SERIAL_LOW       16'h8F06

// Reset values
`define CDT_PEDESTAL_DEF_NEW     8'hB4
`define CDT_PEDESTAL_DEF_OLD     8'h00
`define CDT_CRATE_DEF            8'h00
`define CDT_SLIDE_DEF            8'h00
`define CDT_RD_TEST_ADDR_DEF     11'h000

// Sizes and field positions
`define CDT_FIFO_DEPTH           32
`define CDT_TEST_VALUE_W         12
`define CDT_TEST_OV_BIT          12
`define CDT_THR_KILL_BIT         8
`define CDT_BUF_ADDR_W           11

`endif

// [logic/cdt_pkg.sv]
package cdt_pkg;

    // Register access port from the crate bus
    typedef struct packed {
        logic [15:0] addr;
        logic        wr;
        logic        rd;
        logic [15:0] wdata;
    } cdt_bus_req_t;

    // One test-event word: spare bits, overflow flag, 12-bit value
    typedef struct packed {
        logic [2:0]  spare;
        logic        overflowFlag;
        logic [11:0] value;
    } cdt_test_word_t;

    // Word handed to the output buffer in acquisition test mode
    typedef struct packed {
        logic [4:0]     channel;
        cdt_test_word_t word;
    } cdt_test_out_t;

    typedef enum logic [0:0] {CDT_IDLE, CDT_STREAM} cdt_state_t;

endpackage

// [logic/cdt_test_regs.sv]
`timescale 1ns/1ps
`include "cdt_map.svh"
// Functional notes
// - test word low write loads low 16 bits
// - low write pushes 32-bit pattern to buffer
// - crate number read/write, fed into data words
// - each test event write pushes FIFO entry
// - acquisition test mode streams FIFO as event
// - test word holds 12-bit value plus overflow
// - any counter clear write clears event counter
// - pedestal holds 8-bit common current code
// - pedestal defaults 180 new, 0 old
// - read test address selects buffer read location
// - software conversion write starts one conversion
// - slide constant holds 8-bit DAC value
// - sliding off holds DAC at constant
// - block A location returns latest A conversion
// - block B location returns latest B conversion
// - threshold word per channel, two-byte stride
// - discard flag one drops channel data
// - thresholds cleared only by hardware reset
// - identification returns maker code three bytes
// - identification returns version, board, revision, serial
module cdt_test_regs
    import cdt_pkg::*;
#(
    parameter logic [7:0] MAKER_HIGH = 8'h5A, // Arbitrary value
    parameter logic [7:0] MAKER_MID  = 8'h5B, // Arbitrary value
    parameter logic [7:0] MAKER_LOW  = 8'h5C, // Arbitrary value
    parameter logic [7:0] PURCH_VER  = 8'h21, // Arbitrary value
    parameter logic [7:0] BOARD_HIGH = 8'h01, // Arbitrary value
    parameter logic [7:0] BOARD_MID  = 8'h02, // Arbitrary value
    parameter logic [7:0] BOARD_LOW  = 8'h07, // Arbitrary value
    parameter logic [7:0] HW_REV     = 8'h01, // Arbitrary value
    parameter logic [7:0] SERIAL_HI  = 8'h12, // Arbitrary value
    parameter logic [7:0] SERIAL_LO  = 8'h34  // Arbitrary value
) (
    input  wire logic           clk,
    input  wire logic           sys_rst,
    input  wire logic           hwRst,
    input  wire cdt_bus_req_t   busReq,
    output cdt_test_out_t       testOut,
    output logic [15:0]         rdData,
    output logic                rdValid,
    input  wire logic [15:0]    testWordHigh,
    input  wire logic [10:0]    writeTestAddress,
    input  wire logic           acquisitionTestSelect,
    input  wire logic           slidingScaleOn,
    input  wire logic           frontEndV2,
    input  wire logic           gate,
    input  wire logic           adcAValid,
    input  wire logic [15:0]    adcAData,
    input  wire logic           adcBValid,
    input  wire logic [15:0]    adcBData,
    input  wire logic [4:0]     thrQueryChan,
    output logic [15:0]         thrQueryWord,
    output logic [31:0]         killMask,
    output logic                bufWrEn,
    output logic [10:0]         bufWrAddr,
    output logic [31:0]         bufWrData,
    output logic [10:0]         readTestAddress,
    output logic [7:0]          crateNumber,
    output logic [7:0]          pedestalCode,
    output logic [7:0]          slideDac,
    output logic                testOutValid,
    output logic                evCountClear,
    output logic                swConvert
);

    // Decoded write and read strobes
    logic        wrEn;
    logic        rdEn;
    logic        thrHit;
    logic [4:0]  thrIdx;
    assign wrEn   = busReq.wr;
    assign rdEn   = busReq.rd;
    assign thrHit = (busReq.addr >= `CDT_OFF_THRESHOLD_BASE)
                  && (busReq.addr <= `CDT_OFF_THRESHOLD_LAST) && !busReq.addr[0];
    assign thrIdx = busReq.addr[5:1];

    // Strap sampled every cycle so the reset value is known at release
    logic strapV2;
    always_ff @(posedge clk) begin
        strapV2 <= frontEndV2;
    end

    // Plain settings, all read back except the read test address, which reads zero
    logic [7:0] slideConst;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            crateNumber     <= `CDT_CRATE_DEF;
            pedestalCode    <= strapV2 ? `CDT_PEDESTAL_DEF_NEW
                                       : `CDT_PEDESTAL_DEF_OLD;
            slideConst      <= `CDT_SLIDE_DEF;
            readTestAddress <= `CDT_RD_TEST_ADDR_DEF;
        end else if (wrEn) begin
            if (busReq.addr == `CDT_OFF_CRATE_NUMBER)
                crateNumber <= busReq.wdata[7:0];
            if (busReq.addr == `CDT_OFF_PEDESTAL)
                pedestalCode <= busReq.wdata[7:0];
            if (busReq.addr == `CDT_OFF_SLIDE_CONSTANT)
                slideConst <= busReq.wdata[7:0];
            if (busReq.addr == `CDT_OFF_READ_TEST_ADDR)
                readTestAddress <= busReq.wdata[10:0];
        end
    end

    // Dummy strobes: one-cycle pulses, nothing stored
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            evCountClear <= 1'b0;
            swConvert    <= 1'b0;
        end else begin
            evCountClear <= wrEn && busReq.addr == `CDT_OFF_EVENT_CNT_CLEAR;
            swConvert    <= wrEn && busReq.addr == `CDT_OFF_SOFTWARE_CONV;
        end
    end

    // Direct buffer write: high half comes from the neighbouring register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bufWrEn   <= 1'b0;
            bufWrAddr <= 11'h000;
            bufWrData <= 32'h0000_0000;
        end else begin
            bufWrEn <= wrEn && busReq.addr == `CDT_OFF_TEST_WORD_LOW;
            if (wrEn && busReq.addr == `CDT_OFF_TEST_WORD_LOW) begin
                bufWrAddr <= writeTestAddress;
                bufWrData <= {testWordHigh, busReq.wdata};
            end
        end
    end

    // Sliding scale: ramp per conversion unless disabled
    logic [7:0] slideRamp;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            slideRamp <= 8'h00;
            slideDac  <= `CDT_SLIDE_DEF;
        end else begin
            if (gate || swConvert)
                slideRamp <= slideRamp + 8'h01;
            slideDac <= slidingScaleOn ? slideRamp : slideConst;
        end
    end

    // Latest raw conversions of both blocks
    logic [15:0] adcA;
    logic [15:0] adcB;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            adcA <= 16'h0000;
            adcB <= 16'h0000;
        end else begin
            if (adcAValid)
                adcA <= adcAData;
            if (adcBValid)
                adcB <= adcBData;
        end
    end

    // Threshold memory survives the ordinary reset on purpose
    logic [15:0] thrMem [0:31];
    always_ff @(posedge clk) begin
        if (hwRst) begin
            for (int i = 0; i < 32; i++)
                thrMem[i] <= 16'h0000;
        end else if (wrEn && thrHit) begin
            thrMem[thrIdx] <= busReq.wdata;
        end
    end

    // Discard mask and per-channel lookup for the storage logic
    always_ff @(posedge clk) begin
        if (hwRst) begin
            killMask     <= 32'h0000_0000;
            thrQueryWord <= 16'h0000;
        end else begin
            for (int i = 0; i < 32; i++)
                killMask[i] <= thrMem[i][`CDT_THR_KILL_BIT];
            thrQueryWord <= thrMem[thrQueryChan];
        end
    end

    // Test event FIFO, circular so extra writes overwrite old ones
    cdt_test_word_t fifoMem [0:`CDT_FIFO_DEPTH-1];
    logic [4:0]     fifoWrPtr;
    logic [4:0]     fifoRdPtr;
    logic           selDly;
    logic           pushWord;
    assign pushWord = wrEn && busReq.addr == `CDT_OFF_TEST_EVENT_WR;

    always_ff @(posedge clk) begin
        if (pushWord)
            fifoMem[fifoWrPtr] <= cdt_test_word_t'(busReq.wdata);
    end

    // Select edges restart the pointers, as software expects
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            selDly    <= 1'b0;
            fifoWrPtr <= 5'd0;
        end else begin
            selDly <= acquisitionTestSelect;
            if (acquisitionTestSelect && !selDly)
                fifoWrPtr <= 5'd0;
            else if (pushWord)
                fifoWrPtr <= fifoWrPtr + 5'd1;
        end
    end

    // Streaming of one stored event per gate
    cdt_state_t state;
    cdt_state_t next_state;
    logic [5:0] streamCnt;
    always_comb begin
        next_state = state;
        unique case (state)
            CDT_IDLE:   if (gate && acquisitionTestSelect) next_state = CDT_STREAM;
            CDT_STREAM: if (streamCnt == 6'd31) next_state = CDT_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state     <= CDT_IDLE;
            streamCnt <= 6'd0;
            fifoRdPtr <= 5'd0;
        end else begin
            state <= next_state;
            if (!acquisitionTestSelect && selDly)
                fifoRdPtr <= 5'd0;
            else if (state == CDT_STREAM)
                fifoRdPtr <= fifoRdPtr + 5'd1;
            streamCnt <= (state == CDT_STREAM) ? streamCnt + 6'd1 : 6'd0;
        end
    end

    // Output words carry the interleaved channel number 0,16,1,17...
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            testOutValid <= 1'b0;
            testOut      <= '0;
        end else begin
            testOutValid <= state == CDT_STREAM;
            if (state == CDT_STREAM) begin
                testOut.word    <= fifoMem[fifoRdPtr];
                testOut.channel <= {streamCnt[0], streamCnt[4:1]};
            end
        end
    end

    // Read mux; write-only and unmapped locations read zero
    logic [15:0] next_rdData;
    always_comb begin
        next_rdData = 16'h0000;
        if (thrHit) begin
            next_rdData = thrMem[thrIdx];
        end else begin
            unique case (busReq.addr)
                `CDT_OFF_CRATE_NUMBER:    next_rdData = {8'h00, crateNumber};
                `CDT_OFF_PEDESTAL:        next_rdData = {8'h00, pedestalCode};
                `CDT_OFF_SLIDE_CONSTANT:  next_rdData = {8'h00, slideConst};
                `CDT_OFF_ADC_BLOCK_A:     next_rdData = adcA;
                `CDT_OFF_ADC_BLOCK_B:     next_rdData = adcB;
                `CDT_OFF_MAKER_ID_HIGH:   next_rdData = {8'h00, MAKER_HIGH};
                `CDT_OFF_MAKER_ID_MID:    next_rdData = {8'h00, MAKER_MID};
                `CDT_OFF_MAKER_ID_LOW:    next_rdData = {8'h00, MAKER_LOW};
                `CDT_OFF_PURCHASED_VER:   next_rdData = {8'h00, PURCH_VER};
                `CDT_OFF_BOARD_CODE_HIGH: next_rdData = {8'h00, BOARD_HIGH};
                `CDT_OFF_BOARD_CODE_MID:  next_rdData = {8'h00, BOARD_MID};
                `CDT_OFF_BOARD_CODE_LOW:  next_rdData = {8'h00, BOARD_LOW};
                `CDT_OFF_HW_REVISION:     next_rdData = {8'h00, HW_REV};
                `CDT_OFF_SERIAL_HIGH:     next_rdData = {8'h00, SERIAL_HI};
                `CDT_OFF_SERIAL_LOW:      next_rdData = {8'h00, SERIAL_LO};
                default:                  next_rdData = 16'h0000;
            endcase
        end
    end

    // Read answer one cycle after the request
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdValid <= 1'b0;
            rdData  <= 16'h0000;
        end else begin
            rdValid <= rdEn;
            rdData  <= rdEn ? next_rdData : 16'h0000;
        end
    end

    // Checks
    a_low_write_push: assert property (@(posedge clk) disable iff (sys_rst)
        wrEn && busReq.addr == `CDT_OFF_TEST_WORD_LOW |=>
            bufWrEn && bufWrData == {$past(testWordHigh), $past(busReq.wdata)})
        else $error("test word low write did not reach buffer");
    a_crate_readback: assert property (@(posedge clk) disable iff (sys_rst)
        wrEn && busReq.addr == `CDT_OFF_CRATE_NUMBER && !rdEn ##1 rdEn && !wrEn
            && busReq.addr == `CDT_OFF_CRATE_NUMBER |=>
            rdData[7:0] == $past(busReq.wdata[7:0], 2))
        else $error("crate number readback wrong");
    a_stream_length: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(state == CDT_STREAM) |-> ##32 state == CDT_IDLE)
        else $error("test event not 32 words");
    a_counter_clear: assert property (@(posedge clk) disable iff (sys_rst)
        evCountClear |-> $past(wrEn) && $past(busReq.addr) == `CDT_OFF_EVENT_CNT_CLEAR)
        else $error("counter clear pulse without write");
    a_pedestal_default: assert property (@(posedge clk)
        $fell(sys_rst) |-> pedestalCode == ($past(strapV2) ? 8'hB4 : 8'h00))
        else $error("pedestal default wrong");
    a_soft_convert: assert property (@(posedge clk) disable iff (sys_rst)
        wrEn && busReq.addr == `CDT_OFF_SOFTWARE_CONV
            ##1 !(wrEn && busReq.addr == `CDT_OFF_SOFTWARE_CONV)
            |-> swConvert ##1 !swConvert)
        else $error("software conversion pulse wrong");
    a_slide_hold: assert property (@(posedge clk) disable iff (sys_rst)
        !slidingScaleOn && $stable(slideConst) |=> slideDac == $past(slideConst))
        else $error("slide dac not at constant");
    a_adc_a_latch: assert property (@(posedge clk) disable iff (sys_rst)
        adcAValid |=> adcA == $past(adcAData))
        else $error("block A value not latched");
    a_strobe_reads_zero: assert property (@(posedge clk) disable iff (sys_rst)
        rdEn && busReq.addr == `CDT_OFF_SOFTWARE_CONV |=> rdValid && rdData == 16'h0000)
        else $error("strobe location read not zero");
    // Stored word must sit where the pointer stood at the push
    a_fifo_push_word: assert property (@(posedge clk) disable iff (sys_rst)
        pushWord |=> fifoMem[$past(fifoWrPtr)] == $past(busReq.wdata))
        else $error("test event word not stored");
    a_stream_first_ch: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(testOutValid) |-> testOut.channel == 5'h00 ##1 testOut.channel == 5'h10)
        else $error("test event channel order wrong");
    a_pedestal_write: assert property (@(posedge clk) disable iff (sys_rst)
        wrEn && busReq.addr == `CDT_OFF_PEDESTAL
            |=> pedestalCode == $past(busReq.wdata[7:0]))
        else $error("pedestal write lost");
    // A second write right behind is excluded; it would reach the mask one cycle after the check
    a_kill_follows_write: assert property (@(posedge clk) disable iff (hwRst)
        wrEn && thrHit ##1 !(wrEn && thrHit)
            |=> killMask[$past(thrIdx, 2)] == $past(busReq.wdata[`CDT_THR_KILL_BIT], 2))
        else $error("kill mask does not follow threshold write");

endmodule // cdt_test_regs

// [verif/cdt_host_model.sv]
`timescale 1ns/1ps
`include "cdt_map.svh"
module cdt_host_model
    import cdt_pkg::*;
(
    input  wire logic         clk,
    output cdt_bus_req_t      busReq,
    input  wire logic [15:0]  rdData,
    input  wire logic         rdValid
);
    initial busReq = '{addr: 16'h0000, wr: 1'b0, rd: 1'b0, wdata: 16'h0000};

    // Released lines flip so a stale address or datum never looks current
    task automatic drop();
        busReq.wr = 1'b0;
        busReq.rd = 1'b0;
        busReq.addr = ~busReq.addr;
        busReq.wdata = ~busReq.wdata;
    endtask

    // One-cycle write strobe, launched and released on falling edges
    task automatic write16(input logic [15:0] addr, input logic [15:0] data);
        @(negedge clk);
        busReq.addr = addr;
        busReq.wdata = data;
        busReq.wr = 1'b1;
        @(negedge clk);
        drop();
    endtask

    // Answer stands half a cycle after the taking edge
    task automatic read16(input logic [15:0] addr, output logic [15:0] data,
                          output logic ok);
        @(negedge clk);
        busReq.addr = addr;
        busReq.rd = 1'b1;
        @(negedge clk);
        data = rdData;
        ok = rdValid;
        drop();
    endtask

    // Exactly 32 words, caller supplies them in stream order (channels 0,16,1,17...)
    task automatic load_event(input logic [15:0] words[32]);
        for (int k = 0; k < 32; k++) begin
            write16(`CDT_OFF_TEST_EVENT_WR, words[k]);
        end
    endtask
endmodule // cdt_host_model

// [verif/testbench.sv]
`timescale 1ns/1ps
`include "cdt_map.svh"
module testbench
    import cdt_pkg::*;
;
    // Identity values are arbitrary
    localparam logic [7:0]  ID_VAL[10] = '{8'h9A, 8'h9B, 8'h9C, 8'h2D, 8'h4E,
                                          8'h5F, 8'h6A, 8'h7B, 8'h8C, 8'hA7};
    localparam logic [15:0] ID_ADR[10] = '{16'h8026, 16'h802A, 16'h802E, 16'h8032,
                                          16'h8036, 16'h803A, 16'h803E, 16'h804E,
                                          16'h8F02, 16'h8F06};
    logic clk = 1'b0, sys_rst = 1'b1, hwRst = 1'b1, gate = 1'b0, frontEndV2 = 1'b1;
    logic acquisitionTestSelect = 1'b0, slidingScaleOn = 1'b1;
    logic adcAValid = 1'b0, adcBValid = 1'b0;
    logic [15:0] adcAData = 16'h0000, adcBData = 16'h0000, testWordHigh = 16'h0000;
    logic [10:0] writeTestAddress = 11'h000;
    logic [4:0]  thrQueryChan = 5'h00;
    cdt_bus_req_t  busReq;
    cdt_test_out_t testOut;
    logic [15:0] rdData, thrQueryWord;
    logic [31:0] killMask, bufWrData;
    logic [10:0] bufWrAddr, readTestAddress;
    logic [7:0]  crateNumber, pedestalCode, slideDac;
    logic        rdValid, bufWrEn, testOutValid, evCountClear, swConvert;
    int nErrors = 0;
    int checksDone = 0;

    always #12.5 clk = ~clk;

    cdt_test_regs #(
        .MAKER_HIGH(ID_VAL[0]), .MAKER_MID(ID_VAL[1]), .MAKER_LOW(ID_VAL[2]),
        .PURCH_VER(ID_VAL[3]), .BOARD_HIGH(ID_VAL[4]), .BOARD_MID(ID_VAL[5]),
        .BOARD_LOW(ID_VAL[6]), .HW_REV(ID_VAL[7]), .SERIAL_HI(ID_VAL[8]),
        .SERIAL_LO(ID_VAL[9])
    ) DUT (
        .clk(clk), .sys_rst(sys_rst), .hwRst(hwRst), .busReq(busReq),
        .testOut(testOut), .rdData(rdData), .rdValid(rdValid),
        .testWordHigh(testWordHigh), .writeTestAddress(writeTestAddress),
        .acquisitionTestSelect(acquisitionTestSelect), .slidingScaleOn(slidingScaleOn),
        .frontEndV2(frontEndV2), .gate(gate), .adcAValid(adcAValid),
        .adcAData(adcAData), .adcBValid(adcBValid), .adcBData(adcBData),
        .thrQueryChan(thrQueryChan), .thrQueryWord(thrQueryWord), .killMask(killMask),
        .bufWrEn(bufWrEn), .bufWrAddr(bufWrAddr), .bufWrData(bufWrData),
        .readTestAddress(readTestAddress), .crateNumber(crateNumber),
        .pedestalCode(pedestalCode), .slideDac(slideDac), .testOutValid(testOutValid),
        .evCountClear(evCountClear), .swConvert(swConvert)
    );

    cdt_host_model host (
        .clk(clk), .busReq(busReq), .rdData(rdData), .rdValid(rdValid)
    );

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            nErrors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd_check(input string what, input logic [15:0] addr,
                            input logic [15:0] exp);
        logic [15:0] d;
        logic ok;
        host.read16(addr, d, ok);
        check(what, {16'h0000, d}, {16'h0000, exp});
        check("rdValid", {31'h0, ok}, 32'h0000_0001);
    endtask

    // Test word: spare zero, overflow on odd slots, varied 12-bit value
    function automatic logic [15:0] tw(input int k);
        return {3'b000, k[0], 12'(k * 131 + 5)};
    endfunction

    task automatic pulse_rst(input logic v2);
        frontEndV2 = v2;
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
    endtask

    task automatic test_regs();
        check("pedestal default", {24'h0, pedestalCode}, 32'h0000_00B4);
        host.write16(`CDT_OFF_CRATE_NUMBER, 16'h0005);
        check("crateNumber", {24'h0, crateNumber}, 32'h0000_0005);
        rd_check("crate", `CDT_OFF_CRATE_NUMBER, 16'h0005);
        host.write16(`CDT_OFF_PEDESTAL, 16'hAB4C);
        rd_check("pedestal", `CDT_OFF_PEDESTAL, 16'h004C);
        check("pedestalCode", {24'h0, pedestalCode}, 32'h0000_004C);
        slidingScaleOn = 1'b0;
        host.write16(`CDT_OFF_SLIDE_CONSTANT, 16'h0077);
        @(negedge clk);
        check("slideDac", {24'h0, slideDac}, 32'h0000_0077);
        rd_check("slide", `CDT_OFF_SLIDE_CONSTANT, 16'h0077);
        host.write16(`CDT_OFF_READ_TEST_ADDR, 16'h0456);
        check("readTestAddress", {21'h0, readTestAddress}, 32'h0000_0456);
        rd_check("read test addr", `CDT_OFF_READ_TEST_ADDR, 16'h0000);
        adcAData = 16'h0ABC;
        adcBData = 16'h1DEF;
        adcAValid = 1'b1;
        adcBValid = 1'b1;
        @(negedge clk);
        adcAValid = 1'b0;
        adcBValid = 1'b0;
        host.write16(`CDT_OFF_ADC_BLOCK_A, 16'h5555);
        rd_check("adc A", `CDT_OFF_ADC_BLOCK_A, 16'h0ABC);
        rd_check("adc B", `CDT_OFF_ADC_BLOCK_B, 16'h1DEF);
        $display("test_regs done, errors %0d", nErrors);
    endtask

    task automatic test_strobes();
        host.write16(`CDT_OFF_EVENT_CNT_CLEAR, 16'h0000);
        check("evCountClear", {31'h0, evCountClear}, 32'h0000_0001);
        @(negedge clk);
        check("evCountClear end", {31'h0, evCountClear}, 32'h0000_0000);
        host.write16(`CDT_OFF_SOFTWARE_CONV, 16'hFFFF);
        check("swConvert", {31'h0, swConvert}, 32'h0000_0001);
        @(negedge clk);
        check("swConvert end", {31'h0, swConvert}, 32'h0000_0000);
        rd_check("strobe read", `CDT_OFF_SOFTWARE_CONV, 16'h0000);
        testWordHigh = 16'hA5C3;
        writeTestAddress = 11'h123;
        host.write16(`CDT_OFF_TEST_WORD_LOW, 16'h3C5A);
        check("bufWrEn", {31'h0, bufWrEn}, 32'h0000_0001);
        check("bufWrData", bufWrData, 32'hA5C3_3C5A);
        check("bufWrAddr", {21'h0, bufWrAddr}, 32'h0000_0123);
        $display("test_strobes done, errors %0d", nErrors);
    endtask

    task automatic acquisition_test_select();
        logic [15:0] words[32];
        int i;
        for (int k = 0; k < 32; k++) words[k] = tw(k);
        acquisitionTestSelect = 1'b1;
        @(negedge clk);
        acquisitionTestSelect = 1'b0;
        host.load_event(words);
        acquisitionTestSelect = 1'b1;
        @(negedge clk);
        gate = 1'b1;
        @(negedge clk);
        gate = 1'b0;
        for (i = 0; i < 4 && testOutValid !== 1'b1; i++) @(negedge clk);
        for (int k = 0; k < 32; k++) begin
            check("testOutValid", {31'h0, testOutValid}, 32'h0000_0001);
            check("testOut", {11'h0, testOut}, {11'h0, k[0], k[4:1], tw(k)});
            @(negedge clk);
        end
        check("testOutValid end", {31'h0, testOutValid}, 32'h0000_0000);
        acquisitionTestSelect = 1'b0;
        $display("acquisition_test_select done, errors %0d", nErrors);
    endtask

    task automatic test_thresholds();
        host.write16(16'h1080, 16'h0110);
        host.write16(16'h10A0, 16'h0105);
        host.write16(`CDT_OFF_THRESHOLD_LAST, 16'h0020);
        thrQueryChan = 5'd31;
        @(negedge clk);
        check("killMask", killMask, 32'h0001_0001);
        check("thrQueryWord", {16'h0, thrQueryWord}, 32'h0000_0020);
        rd_check("thr ch16", 16'h10A0, 16'h0105);
        rd_check("thr odd", 16'h1081, 16'h0000);
        pulse_rst(1'b0);
        check("pedestal old", {24'h0, pedestalCode}, 32'h0000_0000);
        rd_check("thr kept", 16'h1080, 16'h0110);
        hwRst = 1'b1;
        @(negedge clk);
        hwRst = 1'b0;
        rd_check("thr cleared", 16'h1080, 16'h0000);
        check("killMask cleared", killMask, 32'h0000_0000);
        pulse_rst(1'b1);
        $display("test_thresholds done, errors %0d", nErrors);
    endtask

    task automatic test_rom();
        for (int i = 0; i < 10; i++) begin
            rd_check("identity", ID_ADR[i], {8'h00, ID_VAL[i]});
        end
        host.write16(ID_ADR[0], 16'h00FF);
        rd_check("identity ro", ID_ADR[0], {8'h00, ID_VAL[0]});
        $display("test_rom done, errors %0d", nErrors);
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checksDone, nErrors);
        if (nErrors == 0 && checksDone > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Hardware reset too, so threshold words start defined
    initial begin
        repeat (6) @(negedge clk);
        sys_rst = 1'b0;
        hwRst = 1'b0;
        test_regs();
        test_strobes();
        acquisition_test_select();
        test_thresholds();
        test_rom();
        report_and_stop();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        nErrors++;
        report_and_stop();
    end
endmodule // testbench
